/* pkg/sas_regs.svh */
// Register indices, field positions, reset values and timing counts of the converter sequencer
`ifndef SAS_REGS_SVH
`define SAS_REGS_SVH

// ==========================================================================
// Register indices on the byte register port
`define SAS_IDX_STATUS      3'h0
`define SAS_IDX_CTRL_ONE    3'h1
`define SAS_IDX_CTRL_TWO    3'h2
`define SAS_IDX_CTRL_THREE  3'h3
`define SAS_IDX_SLOT_FIRST  3'h4
`define SAS_IDX_DATA_BIT    2

// ==========================================================================
// converter_status fields
`define SAS_ST_DONE         0
`define SAS_ST_BUSY         1
`define SAS_ST_OVERRUN      2
`define SAS_ST_PTR_LO       4
`define SAS_ST_RESET        8'h30

// ==========================================================================
// converter_control_one fields
`define SAS_C1_ENABLE       0
`define SAS_C1_IRQ_ENABLE   2

// ==========================================================================
// converter_control_two fields
`define SAS_C2_CHAN_LO      0
`define SAS_C2_REPEAT       4
`define SAS_C2_MULTI_LO     5
`define SAS_C2_START        7
`define SAS_MULTI_SINGLE    2'h0
`define SAS_MULTI_SCAN      2'h1

// ==========================================================================
// converter_control_three fields
`define SAS_C3_DIV_LO       0
`define SAS_C3_DELAY_LO     3
`define SAS_C3_PWREN        6

// ==========================================================================
// Timing: converter clocks per conversion, and the pointer load value
`define SAS_CONV_CLOCKS     4'ha
`define SAS_CONV_LAST       4'h9
`define SAS_PTR_START       2'h3
`define SAS_SLOT_LAST       2'h3
`define SAS_SAR_TOP         8'h80

`endif

/* pkg/sas_pkg.sv */
// Types shared by the converter sequencer modules
`default_nettype none
package sas_pkg;

  typedef enum logic [2:0] {
    SAS_IDLE    = 3'b001,
    SAS_SETTLE  = 3'b010,
    SAS_CONVERT = 3'b100
  } sas_state_t;

  typedef struct packed {
    sas_state_t  state;
    logic        en;
    logic        converter_irq_enable;
    logic        pwren;
    logic        start;
    logic [1:0]  multi;
    logic        repeat_sel;
    logic [3:0]  chan;
    logic [2:0]  clock_divide_field;
    logic [2:0]  delay;
    logic        done;
    logic        overrun;
    logic [1:0]  ptr;
    logic [3:0]  unread;
    logic [1:0]  seq;
    logic [6:0]  cnt;
    logic [3:0]  step;
    logic [7:0]  sar;
    logic [7:0]  mask;
    logic        irq;
    logic        rd_mem;
    logic [7:0]  rdata;
  } sas_seq_t;

  typedef struct packed {
    logic [4:0] cnt;
  } sas_div_t;

  typedef struct packed {
    logic [3:0][7:0] slot;
    logic [7:0]      q;
  } sas_mem_t;

endpackage
`default_nettype wire

/* rtl/sas_clkdiv.sv */
// Converter clock enable divider: one-cycle strobe every 2**code system clocks
`timescale 1ns/1ps
`default_nettype none
module sas_clkdiv (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       run_i,
  input  wire logic [2:0] clock_divide_field_i,
  output logic            tick_o
);

  sas_pkg::sas_div_t s_r;
  sas_pkg::sas_div_t s_nxt;
  logic [4:0]        limit;

  // Reserved codes shift out of six bits and so behave as divide by 32
  assign limit  = 5'((6'h01 << clock_divide_field_i) - 6'h01);
  assign tick_o = run_i && (s_r.cnt == limit);

  always_comb begin
    s_nxt = s_r;
    if (!run_i || tick_o) begin
      s_nxt.cnt = 5'h00;
    end else begin
      s_nxt.cnt = s_r.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

/* rtl/sas_result_mem.sv */
// Four-slot result buffer with one write port and a registered read port
`timescale 1ns/1ps
`default_nettype none
module sas_result_mem (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       we_i,
  input  wire logic [1:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       re_i,
  input  wire logic [1:0] raddr_i,
  output logic      [7:0] rdata_o
);

  sas_pkg::sas_mem_t s_r;
  sas_pkg::sas_mem_t s_nxt;

  assign rdata_o = s_r.q;

  always_comb begin
    s_nxt = s_r;
    if (re_i) begin
      s_nxt.q = s_r.slot[raddr_i];
    end
    if (we_i) begin
      s_nxt.slot[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

/* rtl/sas_sequencer.sv */
// Successive-approximation converter sequencer: registers, mode control and result buffer
`timescale 1ns/1ps
`default_nettype none
`include "sas_regs.svh"
module sas_sequencer #(
  parameter int NUM_CH = 12,
  parameter int DATA_W = 8
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] reg_idx_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic      [3:0] chan_o,
  output logic            sample_o,
  output logic      [7:0] dac_code_o,
  input  wire logic       comp_i,
  output logic            power_en_o,
  output logic            irq_o
);

  // ==========================================================================
  // Elaboration checks
  generate
    if (DATA_W != 8) begin : g_bad_width
      $error("sas_sequencer: result width must be 8");
    end
    if (NUM_CH < 4 || NUM_CH > 16) begin : g_bad_chan
      $error("sas_sequencer: channel count must be 4 to 16");
    end
  endgenerate

  // ==========================================================================
  // State and helpers
  sas_pkg::sas_seq_t s_r;
  sas_pkg::sas_seq_t s_nxt;
  logic              tick;
  logic              running;
  logic              mem_we;
  logic [1:0]        mem_waddr;
  logic              mem_re;
  logic [7:0]        mem_q;
  logic [6:0]        delay_last;
  logic [1:0]        slot;
  logic              is_scan;
  logic              wr_status;
  logic              wr_ctl1;
  logic              wr_ctl2;
  logic              wr_ctl3;
  logic              rd_slot;
  logic              start_rise;
  logic              set_done;

  assign running    = (s_r.state != sas_pkg::SAS_IDLE);
  // Reserved delay code 111 follows the same rule and gives 128 converter clocks
  assign delay_last = 7'((8'h01 << s_r.delay) - 8'h01);
  assign slot       = s_r.ptr + 2'h1;
  assign is_scan    = (s_r.multi == `SAS_MULTI_SCAN);
  assign wr_status  = reg_wr_i && (reg_idx_i == `SAS_IDX_STATUS);
  assign wr_ctl1    = reg_wr_i && (reg_idx_i == `SAS_IDX_CTRL_ONE);
  assign wr_ctl2    = reg_wr_i && (reg_idx_i == `SAS_IDX_CTRL_TWO);
  assign wr_ctl3    = reg_wr_i && (reg_idx_i == `SAS_IDX_CTRL_THREE);
  assign rd_slot    = reg_rd_i && reg_idx_i[`SAS_IDX_DATA_BIT];
  assign start_rise = wr_ctl2 && reg_wdata_i[`SAS_C2_START] && !s_r.start && s_r.en;
  assign mem_re     = rd_slot;
  assign mem_waddr  = slot;

  // ==========================================================================
  // Outputs toward the analog core and the CPU
  // Scan adds the sequence index; channels above the top are left to the mux
  assign chan_o      = s_r.chan + (is_scan ? {2'h0, s_r.seq} : 4'h0);
  // Sample-and-hold tracks during settling and the first conversion clock
  assign sample_o    = (s_r.state == sas_pkg::SAS_SETTLE) ||
                       ((s_r.state == sas_pkg::SAS_CONVERT) && (s_r.step == 4'h0));
  assign dac_code_o  = s_r.sar;
  assign power_en_o  = s_r.en || !s_r.pwren;
  assign irq_o       = s_r.irq;
  assign reg_rdata_o = s_r.rd_mem ? mem_q : s_r.rdata;

  sas_clkdiv u_div (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .run_i   (running),
    .clock_divide_field_i  (s_r.clock_divide_field),
    .tick_o  (tick)
  );

  sas_result_mem u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (s_r.sar),
    .re_i    (mem_re),
    .raddr_i (reg_idx_i[1:0]),
    .rdata_o (mem_q)
  );

  // ==========================================================================
  // Next-state logic: software accesses first, hardware events after so they win
  always_comb begin
    s_nxt        = s_r;
    s_nxt.irq    = 1'b0;
    mem_we       = 1'b0;
    set_done     = 1'b0;

    // Register reads answer one cycle later; the source select holds until the next read
    if (reg_rd_i) begin
      s_nxt.rd_mem = 1'b0;
      case (reg_idx_i)
        `SAS_IDX_STATUS: begin
          s_nxt.rdata = {2'h0, s_r.ptr, 1'b0, s_r.overrun, running, s_r.done};
        end
        `SAS_IDX_CTRL_ONE: begin
          s_nxt.rdata = {5'h00, s_r.converter_irq_enable, 1'b0, s_r.en};
        end
        `SAS_IDX_CTRL_TWO: begin
          s_nxt.rdata = {s_r.start, s_r.multi, s_r.repeat_sel, s_r.chan};
        end
        `SAS_IDX_CTRL_THREE: begin
          s_nxt.rdata = {1'b0, s_r.pwren, s_r.delay, s_r.clock_divide_field};
        end
        default: begin
          s_nxt.rd_mem = 1'b1;
        end
      endcase
    end
    if (rd_slot) begin
      s_nxt.done                  = 1'b0;
      s_nxt.unread[reg_idx_i[1:0]] = 1'b0;
    end

    // Only the overrun bit of the status register is writable
    if (wr_status && reg_wdata_i[`SAS_ST_OVERRUN]) begin
      s_nxt.overrun = 1'b0;
    end
    if (wr_ctl1) begin
      s_nxt.en   = reg_wdata_i[`SAS_C1_ENABLE];
      s_nxt.converter_irq_enable = reg_wdata_i[`SAS_C1_IRQ_ENABLE];
    end
    if (wr_ctl2) begin
      s_nxt.chan = reg_wdata_i[`SAS_C2_CHAN_LO +: 4];
      // Mode fields are frozen while a start is pending
      if (!s_r.start) begin
        s_nxt.multi      = reg_wdata_i[`SAS_C2_MULTI_LO +: 2];
        s_nxt.repeat_sel = reg_wdata_i[`SAS_C2_REPEAT];
      end
      s_nxt.start = reg_wdata_i[`SAS_C2_START] && s_r.en;
    end
    if (wr_ctl3) begin
      s_nxt.clock_divide_field  = reg_wdata_i[`SAS_C3_DIV_LO +: 3];
      s_nxt.delay = reg_wdata_i[`SAS_C3_DELAY_LO +: 3];
      s_nxt.pwren = reg_wdata_i[`SAS_C3_PWREN];
    end
    if (start_rise) begin
      s_nxt.ptr   = `SAS_PTR_START;
      s_nxt.seq   = 2'h0;
      s_nxt.cnt   = 7'h00;
      s_nxt.state = sas_pkg::SAS_SETTLE;
    end

    // Sequencer, advanced on each converter clock strobe
    case (s_r.state)
      sas_pkg::SAS_IDLE: begin
      end
      sas_pkg::SAS_SETTLE: begin
        if (tick) begin
          if (s_r.cnt == delay_last) begin
            s_nxt.cnt   = 7'h00;
            s_nxt.step  = 4'h0;
            s_nxt.state = sas_pkg::SAS_CONVERT;
          end else begin
            s_nxt.cnt = s_r.cnt + 7'h01;
          end
        end
      end
      sas_pkg::SAS_CONVERT: begin
        if (tick) begin
          s_nxt.step = s_r.step + 4'h1;
          if (s_r.step == 4'h0) begin
            s_nxt.sar  = `SAS_SAR_TOP;
            s_nxt.mask = `SAS_SAR_TOP;
          end else if (s_r.step != `SAS_CONV_LAST) begin
            // Drop the trial bit when the level is above the input, try the next
            s_nxt.sar  = (comp_i ? s_r.sar : (s_r.sar & ~s_r.mask)) | (s_r.mask >> 1);
            s_nxt.mask = s_r.mask >> 1;
          end else begin
            // Tenth converter clock: store and decide what follows
            mem_we       = 1'b1;
            s_nxt.ptr    = slot;
            s_nxt.unread[slot] = 1'b1;
            if (s_r.unread[slot]) begin
              s_nxt.overrun = 1'b1;
            end
            s_nxt.cnt   = 7'h00;
            s_nxt.state = sas_pkg::SAS_SETTLE;
            if (!is_scan && !s_r.repeat_sel) begin
              set_done    = 1'b1;
              s_nxt.start = 1'b0;
              s_nxt.state = sas_pkg::SAS_IDLE;
            end else if (!is_scan) begin
              if (!s_nxt.start) begin
                set_done    = 1'b1;
                s_nxt.state = sas_pkg::SAS_IDLE;
              end else if (slot == `SAS_SLOT_LAST) begin
                set_done = 1'b1;
              end
            end else begin
              s_nxt.seq = s_r.seq + 2'h1;
              if (s_r.seq == `SAS_SLOT_LAST) begin
                set_done = 1'b1;
                if (!s_r.repeat_sel) begin
                  s_nxt.start = 1'b0;
                  s_nxt.state = sas_pkg::SAS_IDLE;
                end else if (!s_nxt.start) begin
                  s_nxt.state = sas_pkg::SAS_IDLE;
                end
              end
            end
          end
        end
      end
      default: begin
        s_nxt.state = sas_pkg::SAS_IDLE;
      end
    endcase

    if (set_done) begin
      s_nxt.done = 1'b1;
      s_nxt.irq  = s_r.converter_irq_enable;
    end

    // Disabling aborts everything; buffered data stays but counts as read
    if (!s_nxt.en) begin
      s_nxt.state   = sas_pkg::SAS_IDLE;
      s_nxt.start   = 1'b0;
      s_nxt.done    = 1'b0;
      s_nxt.overrun = 1'b0;
      s_nxt.unread  = 4'h0;
      s_nxt.irq     = 1'b0;
      s_nxt.seq     = 2'h0;
      s_nxt.cnt     = 7'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r       <= '0;
      s_r.state <= sas_pkg::SAS_IDLE;
      s_r.ptr   <= `SAS_PTR_START;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

/* dv/sas_seq_properties.sv */
// Port-level assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sas_regs.svh"
module sas_seq_properties (
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  input wire logic [2:0] reg_idx_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [3:0] chan_o,
  input wire logic       sample_o,
  input wire logic       irq_o
);
  logic en_r;
  logic ie_r;
  logic st_rd;
  // Shadow of the enable bits, since the checker cannot see the registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_r <= 1'b0;
      ie_r <= 1'b0;
    end else if (reg_wr_i && reg_idx_i == `SAS_IDX_CTRL_ONE) begin
      en_r <= reg_wdata_i[`SAS_C1_ENABLE];
      ie_r <= reg_wdata_i[`SAS_C1_IRQ_ENABLE];
    end
  end
  assign st_rd = reg_rd_i && reg_idx_i == `SAS_IDX_STATUS;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  irq_pulse_a: assert property (irq_o |=> !irq_o)
    else $error("interrupt pulse too long");
  irq_gate_a: assert property (irq_o |-> $past(ie_r) && $past(en_r))
    else $error("interrupt while masked");
  rsvd_bits_a: assert property (st_rd |=> reg_rdata_o[7:6] == 2'h0 && !reg_rdata_o[3])
    else $error("reserved status bits set");
  busy_read_a: assert property (st_rd && sample_o |=> reg_rdata_o[`SAS_ST_BUSY])
    else $error("busy low while sampling");
  off_flags_a: assert property (st_rd && !en_r |=> reg_rdata_o[2:0] == 3'h0)
    else $error("flags set while disabled");
  off_idle_a: assert property (!en_r |-> !sample_o)
    else $error("sampling while disabled");
  chan_hold_a: assert property (disable iff (!rst_n_i || !en_r) $fell(sample_o) |-> $stable(chan_o)[*6])
    else $error("channel moved in conversion");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
endmodule
bind sas_sequencer sas_seq_properties u_chk (.clk_i, .rst_n_i, .reg_idx_i, .reg_wr_i, .reg_rd_i,
  .reg_wdata_i, .reg_rdata_o, .chan_o, .sample_o, .irq_o);
`default_nettype wire

/* dv/sas_core_model.sv */
// Behavioural analog core: sample-and-hold and comparator
`timescale 1ns/1ps
`default_nettype none
module sas_core_model (
  input  wire logic       clk_i,
  input  wire logic [3:0] chan_i,
  input  wire logic       sample_i,
  input  wire logic [7:0] dac_i,
  output logic            comp_o
);
  logic [7:0] held_r = 8'h00;
  // Distinct level per input, so a wrong channel shows in the result
  function automatic logic [7:0] sas_lvl(input logic [3:0] ch);
    return 8'h13 * {4'h0, ch} + 8'h07;
  endfunction
  // Tracks only while sampling; a late channel change is not seen
  always_ff @(posedge clk_i) begin
    if (sample_i) begin
      held_r <= sas_lvl(chan_i);
    end
  end
  assign comp_o = (held_r >= dac_i);
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking testbench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sas_regs.svh"
module tb;
  localparam logic [2:0] ST = `SAS_IDX_STATUS;
  localparam logic [2:0] C1 = `SAS_IDX_CTRL_ONE;
  localparam logic [2:0] C2 = `SAS_IDX_CTRL_TWO;
  localparam logic [2:0] C3 = `SAS_IDX_CTRL_THREE;
  localparam logic [2:0] S0 = `SAS_IDX_SLOT_FIRST;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       reg_wr_i = 1'b0;
  logic       reg_rd_i = 1'b0;
  logic [2:0] reg_idx_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic [7:0] dac_code_o;
  logic [3:0] chan_o;
  logic       sample_o;
  logic       comp_i;
  logic       irq_o;
  logic       power_en_o;
  int         err_count = 0;
  int         checks = 0;
  int         n;
  always #20 clk_i = ~clk_i;
  sas_sequencer uut (.clk_i, .rst_n_i, .reg_idx_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .chan_o, .sample_o, .dac_code_o, .comp_i, .power_en_o, .irq_o);
  sas_core_model core (.clk_i, .chan_i(chan_o), .sample_i(sample_o), .dac_i(dac_code_o), .comp_o(comp_i));
  // ==========================================================================
  // Bus and check helpers
  task automatic test_done();
    if (err_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] lvl(input int ch);
    return 8'h13 * ch[7:0] + 8'h07;
  endfunction
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_i);
    reg_idx_i <= i;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] i, input logic [7:0] e);
    @(posedge clk_i);
    reg_idx_i <= i;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk(reg_rdata_o, e);
  endtask
  task automatic wirq(input int lim, output int k);
    k = 0;
    while (irq_o !== 1'b1) begin
      @(posedge clk_i);
      #1;
      k++;
      if (k > lim) begin
        err_count++;
        $display("[ERR] %0t got %h exp %h", $time, irq_o, 1'b1);
        test_done();
      end
    end
  endtask
  // Disable first, configure, enable, then let the analog side settle
  task automatic on(input logic [7:0] c3, input logic [7:0] c1);
    wr(C1, 8'h00);
    wr(C3, c3);
    wr(C1, c1);
    repeat (750) @(posedge clk_i);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd(ST, 8'h30);
    wr(ST, 8'hff);
    rd(ST, 8'h30);
  endtask
  task automatic t_once();
    on(8'h00, 8'h05);
    wr(C2, 8'h83);
    rd(ST, 8'h32);
    wirq(100, n);
    rd(ST, 8'h01);
    rd(C2, 8'h03);
    rd(S0, lvl(3));
    rd(ST, 8'h00);
  endtask
  task automatic t_scan_once();
    on(8'h00, 8'h05);
    wr(C2, 8'ha4);
    wirq(200, n);
    rd(ST, 8'h31);
    rd(C2, 8'h24);
    for (int k = 0; k < 4; k++) rd(3'(4 + k), lvl(4 + k));
  endtask
  task automatic t_single_rep();
    on(8'h00, 8'h05);
    wr(C2, 8'h92);
    wirq(200, n);
    rd(ST, 8'h33);
    wirq(200, n);
    rd(C2, 8'h92);
    wr(C2, 8'h12);
    wirq(100, n);
    rd(ST, 8'h05);
    wr(ST, 8'h00);
    rd(ST, 8'h05);
    wr(ST, 8'h04);
    rd(ST, 8'h01);
    rd(S0, lvl(2));
  endtask
  task automatic t_scan_rep();
    on(8'h00, 8'h05);
    wr(C2, 8'hb8);
    wirq(200, n);
    wr(C2, 8'h38);
    wirq(200, n);
    rd(ST, 8'h35);
    for (int k = 0; k < 4; k++) rd(3'(4 + k), lvl(8 + k));
  endtask
  task automatic t_abort();
    on(8'h30, 8'h05);
    wr(C2, 8'h80);
    rd(ST, 8'h32);
    wr(C1, 8'h04);
    rd(ST, 8'h30);
    rd(C2, 8'h00);
    wr(C3, 8'h40);
    @(negedge clk_i);
    chk({7'h00, power_en_o}, 8'h00);
    wr(C1, 8'h05);
    @(negedge clk_i);
    chk({7'h00, power_en_o}, 8'h01);
  endtask
  task automatic t_mask();
    on(8'h00, 8'h01);
    wr(C2, 8'h85);
    n = 0;
    repeat (60) begin
      @(posedge clk_i);
      #1;
      if (irq_o !== 1'b0) n++;
    end
    chk(8'(n), 8'h00);
    rd(ST, 8'h01);
  endtask
  // Codes 0..5 of divide and delay, then delay 6 at full rate
  task automatic t_timing();
    int d;
    int s;
    for (int i = 0; i < 7; i++) begin
      d = 1 << (i % 6);
      s = (1 << i) + 10;
      on(8'(i * 8 + (i % 6)), 8'h05);
      wr(C2, 8'h81);
      wirq(3000, n);
      checks++;
      if (n < s * d - 2 || n > s * d + d + 3) begin
        err_count++;
        $display("[ERR] %0t got %h exp %h", $time, n, s * d);
      end
      rd(S0, lvl(1));
    end
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_once();
    t_scan_once();
    t_single_rep();
    t_scan_rep();
    t_abort();
    t_mask();
    t_timing();
    test_done();
  end
endmodule
`default_nettype wire
